/* File: smpsq_pkg.sv */
// Shared constants and types of the power-good and fault sequencer
package smpsq_pkg;

  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_MHZ      = 200;
  localparam int unsigned PG_DELAY_US  = 20;
  localparam int unsigned PG_DELAY_CYC = PG_DELAY_US * CLK_MHZ;
  localparam int unsigned RAMP_MS      = 1;
  localparam int unsigned RAMP_CYC     = RAMP_MS * 1000 * CLK_MHZ;
  localparam int          TMR_W        = 18;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_STATUS   = 8'h00;
  localparam logic [7:0] OFS_INT_STAT = 8'h04;
  localparam logic [7:0] OFS_INT_MASK = 8'h08;

  // ==========================================================
  // Interrupt bits
  localparam int          INT_W        = 5;
  localparam int          EV_OV        = 0;
  localparam int          EV_UV        = 1;
  localparam int          EV_THERM     = 2;
  localparam int          EV_PGLOST    = 3;
  localparam int          EV_LOCK      = 4;
  localparam logic [4:0]  INT_STAT_RST = 5'h00;
  localparam logic [4:0]  INT_MASK_RST = 5'h00;

  // ==========================================================
  // Status fields
  localparam int ST_OV    = 0;
  localparam int ST_UV    = 2;
  localparam int ST_THERM = 4;
  localparam int ST_PG    = 5;
  localparam int ST_RUN   = 6;
  localparam int ST_LOCK  = 8;
  localparam int ST_POR   = 9;
  localparam int ST_W     = 10;

  // ==========================================================
  // Input bundle width
  localparam int SYNC_W = 15;

  // ==========================================================
  // Channel states
  typedef enum logic [2:0] {
    CH_OFF,
    CH_START,
    CH_PGWAIT,
    CH_RUN,
    CH_STOP,
    CH_CLAMP
  } smpsq_ch_t;

endpackage

/* File: smpsq_sync.sv */
// Two-flop synchroniser for a bundle of level inputs
`timescale 1ns/1ps
module smpsq_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // Levels
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= d_in;
      sync_r <= meta_r;
    end
  end

  assign q_out = sync_r;

endmodule

/* File: smpsq_sysctl_model.sv */
// System controller model: drives the enables and reads the power-good line
`timescale 1ns/1ps
module smpsq_sysctl_model (
  // Clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // Requests from the bench
  input wire logic [1:0] req_en,
  input wire logic       req_ldo,
  input wire logic       slow,
  // Power-good pin
  input wire logic       power_good_out_o,
  input wire logic       power_good_out_oe,
  // Enables and resolved line
  output logic           output1_enable,
  output logic           output2_enable,
  output logic           linear_reg_enable,
  output logic           pg_line
);
  logic [1:0] en_r;
  logic [1:0] en_dly_r;

  // ==========================================================
  // enable toggles restart
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_r              <= 2'h0;
      en_dly_r          <= 2'h0;
      linear_reg_enable <= 1'b0;
    end else begin
      en_dly_r          <= req_en;
      en_r              <= slow ? en_dly_r : req_en;
      linear_reg_enable <= req_ldo;
    end
  end
  assign output1_enable = en_r[0];
  assign output2_enable = en_r[1];

  // ==========================================================
  // Pull-up resistor on the open-drain line
  assign pg_line = power_good_out_oe ? power_good_out_o : 1'b1;
endmodule

/* File: smpsq_tmr.sv */
// Loadable down-counter with a one-cycle expiry pulse
`timescale 1ns/1ps
module smpsq_tmr
  import smpsq_pkg::*;
(
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // Control
  input  wire logic             load,
  input  wire logic [TMR_W-1:0] load_val,
  output logic                  done
);

  logic [TMR_W-1:0] cnt_r;
  logic             done_r;
  wire              last = (cnt_r == TMR_W'(1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r  <= '0;
      done_r <= 1'b0;
    end else begin
      done_r <= !load && last;
      if (load) begin
        cnt_r <= load_val;
      end else if (cnt_r != '0) begin
        cnt_r <= cnt_r - TMR_W'(1);
      end
    end
  end

  assign done = done_r;

endmodule

/* File: smpsq_top.sv */
// Power-good, fault latch and gate-state sequencer for a dual step-down controller
// Notes on behaviour
// - power-good held low while either enable is low, and in soft-start or soft-stop.
// - power-good released 20 us after soft-start, only while both outputs are good.
// - power-good low when an output drops 15% low or the controller is off.
// - overvoltage pulls power-good low, sets its latch, and drives low-side gate high.
// - overvoltage and undervoltage latches clear only on enable toggle or supply cycle.
// - 30% undervoltage pulls power-good low, sets its latch, starts soft-shutdown.
// - over-temperature sets its latch, power-good low, discharge on, both gates low.
// - thermal restart needs a linear-regulator enable toggle and cooling, or a supply cycle.
// - falling enable or undervoltage latch starts soft-shutdown with forced PWM and ramp down.
// - after soft-shutdown, output near zero, low-side gate high and high-side low.
// - overvoltage stops the controller, slews the target down, stays off until restart.
// - lockout on a falling supply or thermal latch drives both gates low.
// - lockout on a rising supply keeps switching off, discharge on, low-side high.
// - below power-on level switching off, discharge on, low-side high, high-side low.
// - supply above power-on level clears latches, low-side on, soft-start reset.
// - soft-shutdown ramps the target down over 1 ms before the near-zero check.
//
// The placing of the registers and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module smpsq_top
  import smpsq_pkg::*;
#(
  parameter int unsigned RAMP_CYCLES = RAMP_CYC
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // Enables
  input  wire logic        output1_enable,
  input  wire logic        output2_enable,
  input  wire logic        linear_reg_enable,
  // Supply flags
  input  wire logic        supply_por_ok,
  input  wire logic        supply_lockout,
  // Output comparators, one bit per output
  input  wire logic [1:0]  vout_over,
  input  wire logic [1:0]  vout_under,
  input  wire logic [1:0]  vout_pg_ok,
  input  wire logic [1:0]  vout_near_zero,
  // Temperature flags
  input  wire logic        temp_over,
  input  wire logic        temp_cooled,
  // Power-good open-drain pin
  output logic             power_good_out_o,
  output logic             power_good_out_oe,
  // Gate driver and controller state, one bit per output except the shared discharge_en
  output logic      [1:0]  gate_override,
  output logic      [1:0]  low_side_gate,
  output logic      [1:0]  high_side_gate,
  output logic      [1:0]  switching_en,
  output logic      [1:0]  forced_pwm,
  output logic      [1:0]  error_amp_ramp_up,
  output logic      [1:0]  error_amp_ramp_dn,
  output logic             discharge_en,
  // Interrupt
  output logic             irq
);

  // ==========================================================
  // Input synchronisation
  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] syn;

  assign raw_in = {temp_cooled, temp_over, vout_near_zero, vout_pg_ok, vout_under,
                   vout_over, supply_lockout, supply_por_ok, linear_reg_enable,
                   output2_enable, output1_enable};

  smpsq_sync #(.W(SYNC_W)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d_in    (raw_in),
    .q_out   (syn)
  );

  wire [1:0] en       = syn[1:0];
  wire       ldo_en   = syn[2];
  wire       por_ok   = syn[3];
  wire       lockout  = syn[4];
  wire [1:0] ov_in    = syn[6:5];
  wire [1:0] uv_in    = syn[8:7];
  wire [1:0] pg_in    = syn[10:9];
  wire [1:0] nz_in    = syn[12:11];
  wire       hot_in   = syn[13];
  wire       cool_in  = syn[14];

  // ==========================================================
  // Edge history and supply tracking
  logic [1:0] en_d_r;
  logic       ldo_d_r;
  logic       lock_d_r;
  logic       was_good_r;
  logic       ldo_tog_r;

  wire en_toggle  = |(en ^ en_d_r);
  wire ldo_toggle = ldo_en ^ ldo_d_r;
  wire lock_rise  = lockout && !lock_d_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_d_r     <= 2'h0;
      ldo_d_r    <= 1'b0;
      lock_d_r   <= 1'b0;
      was_good_r <= 1'b0;
    end else begin
      en_d_r   <= en;
      ldo_d_r  <= ldo_en;
      lock_d_r <= lockout;
      if (!por_ok) begin
        was_good_r <= 1'b0;
      end else if (!lockout) begin
        was_good_r <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Fault latches
  logic [1:0] ov_l_r;
  logic [1:0] uv_l_r;
  logic       th_l_r;
  logic [1:0] ov_set;
  logic [1:0] uv_set;
  logic       th_set;
  logic [1:0] ch_active;

  assign ov_set = ov_in & {2{por_ok && !lockout}} & ~ov_l_r;
  assign uv_set = uv_in & ch_active & ~uv_l_r;
  assign th_set = hot_in && por_ok && !th_l_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ov_l_r    <= 2'h0;
      uv_l_r    <= 2'h0;
      th_l_r    <= 1'b0;
      ldo_tog_r <= 1'b0;
    end else if (!por_ok) begin
      ov_l_r    <= 2'h0;
      uv_l_r    <= 2'h0;
      th_l_r    <= 1'b0;
      ldo_tog_r <= 1'b0;
    end else begin
      // enable toggle clears, a new fault wins
      ov_l_r <= (en_toggle ? 2'h0 : ov_l_r) | ov_set;
      uv_l_r <= (en_toggle ? 2'h0 : uv_l_r) | uv_set;
      // thermal restart after toggle and cooling
      if (th_set) begin
        th_l_r    <= 1'b1;
        ldo_tog_r <= 1'b0;
      end else if (th_l_r && ldo_tog_r && cool_in) begin
        th_l_r    <= 1'b0;
        ldo_tog_r <= 1'b0;
      end else if (th_l_r && ldo_toggle) begin
        ldo_tog_r <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Channel sequencers
  wire run_ok       = por_ok && !lockout && !th_l_r;
  wire lock_falling = lockout && was_good_r;
  wire lock_rising  = lockout && !was_good_r;

  smpsq_ch_t        st_r   [2];
  smpsq_ch_t        st_nxt [2];
  logic [1:0]       t_load;
  logic [1:0]       t_done;
  logic [TMR_W-1:0] t_val  [2];
  logic [1:0]       ch_run;
  logic [1:0]       ch_off;
  logic [1:0]       ch_stop;
  logic [1:0]       ch_start;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ch
      smpsq_tmr u_tmr (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .load     (t_load[gi]),
        .load_val (t_val[gi]),
        .done     (t_done[gi])
      );

      always_comb begin
        st_nxt[gi] = st_r[gi];
        t_load[gi] = 1'b0;
        t_val[gi]  = TMR_W'(RAMP_CYCLES);
        // overvoltage or lost supply stops at once
        if (!run_ok || ov_l_r[gi]) begin
          st_nxt[gi] = CH_OFF;
        end else begin
          case (st_r[gi])
            CH_OFF: begin
              if (en[gi] && !uv_l_r[gi]) begin
                st_nxt[gi] = CH_START;
                t_load[gi] = 1'b1;
              end
            end
            CH_START, CH_PGWAIT, CH_RUN: begin
              // falling enable or undervoltage starts soft-stop
              if (!en[gi] || uv_l_r[gi]) begin
                st_nxt[gi] = CH_STOP;
                t_load[gi] = 1'b1;
              end else if (st_r[gi] == CH_START && t_done[gi]) begin
                st_nxt[gi] = CH_PGWAIT;
                t_load[gi] = 1'b1;
                t_val[gi]  = TMR_W'(PG_DELAY_CYC);
              end else if (st_r[gi] == CH_PGWAIT && t_done[gi]) begin
                st_nxt[gi] = CH_RUN;
              end
            end
            CH_STOP: begin
              // ramp down for the full period
              if (t_done[gi]) begin
                st_nxt[gi] = CH_CLAMP;
              end
            end
            CH_CLAMP: begin
              // done once output is near zero
              if (nz_in[gi]) begin
                st_nxt[gi] = CH_OFF;
              end
            end
            default: begin
              st_nxt[gi] = CH_OFF;
            end
          endcase
        end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          st_r[gi] <= CH_OFF;
        end else begin
          st_r[gi] <= st_nxt[gi];
        end
      end

      assign ch_run[gi]    = (st_r[gi] == CH_RUN);
      assign ch_off[gi]    = (st_r[gi] == CH_OFF);
      assign ch_stop[gi]   = (st_r[gi] == CH_STOP) || (st_r[gi] == CH_CLAMP);
      assign ch_start[gi]  = (st_r[gi] == CH_START);
      assign ch_active[gi] = (st_r[gi] == CH_PGWAIT) || ch_run[gi];
    end
  endgenerate

  // ==========================================================
  // Gate and controller decisions
  logic [1:0] clamp;
  logic [1:0] both_low;
  logic [1:0] ovr_nxt;
  logic [1:0] dl_nxt;
  logic [1:0] sw_nxt;

  // below power-on, rising lockout, overvoltage clamp, stopped
  assign clamp    = {2{!por_ok || lock_rising}} | ov_l_r | ch_off;
  // falling lockout or thermal latch, both gates low
  assign both_low = {2{por_ok && (lock_falling || th_l_r)}};
  assign ovr_nxt  = clamp | both_low;
  assign dl_nxt   = clamp & ~both_low;
  assign sw_nxt   = ~ch_off & {2{run_ok}} & ~ov_l_r;

  // ==========================================================
  // Power-good decision
  // held low unless both run and both good
  wire pg_release = &ch_run && &en && &pg_in && run_ok && !(|ov_l_r) && !(|uv_l_r)
                    && !(|ov_set) && !(|uv_set) && !th_set;

  // ==========================================================
  // Driven outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gate_override     <= 2'h3;
      low_side_gate     <= 2'h3;
      high_side_gate    <= 2'h0;
      switching_en      <= 2'h0;
      forced_pwm        <= 2'h0;
      error_amp_ramp_up <= 2'h0;
      error_amp_ramp_dn <= 2'h0;
      discharge_en      <= 1'b1;
      power_good_out_o  <= 1'b0;
      power_good_out_oe <= 1'b1;
    end else begin
      gate_override     <= ovr_nxt;
      low_side_gate     <= dl_nxt;
      high_side_gate    <= 2'h0;
      switching_en      <= sw_nxt;
      forced_pwm        <= ch_stop & sw_nxt;
      error_amp_ramp_up <= ch_start & sw_nxt;
      error_amp_ramp_dn <= ch_stop | ov_l_r;
      discharge_en      <= !por_ok || lockout || th_l_r;
      power_good_out_o  <= 1'b0;
      power_good_out_oe <= !pg_release;
    end
  end

  // ==========================================================
  // Interrupt status and mask
  logic [INT_W-1:0] int_stat_r;
  logic [INT_W-1:0] int_mask_r;
  logic [INT_W-1:0] int_ev;

  assign int_ev[EV_OV]     = |ov_set;
  assign int_ev[EV_UV]     = |uv_set;
  assign int_ev[EV_THERM]  = th_set;
  assign int_ev[EV_PGLOST] = !pg_release && !power_good_out_oe;
  assign int_ev[EV_LOCK]   = lock_rise;

  // ==========================================================
  // AHB-Lite slave
  logic       wr_pend_r;
  logic [7:0] wr_ofs_r;
  logic       irq_r;

  wire        a_valid = hsel && htrans[1] && hready;
  wire [7:0]  a_ofs   = haddr[7:0];
  wire        a_hit   = (haddr[31:8] == 24'h000000);
  wire        wr_stat = wr_pend_r && (wr_ofs_r == OFS_INT_STAT);
  wire        wr_mask = wr_pend_r && (wr_ofs_r == OFS_INT_MASK);

  wire [ST_W-1:0] status_v = {por_ok, lockout, ch_run, !power_good_out_oe, th_l_r,
                              uv_l_r, ov_l_r};

  wire [31:0] rd_status = {{(32 - ST_W){1'b0}}, status_v};
  wire [31:0] rd_stat   = {{(32 - INT_W){1'b0}}, int_stat_r};
  wire [31:0] rd_mask   = {{(32 - INT_W){1'b0}}, int_mask_r};
  wire [31:0] rd_mux    = !a_hit                   ? 32'h00000000 :
                          (a_ofs == OFS_STATUS)    ? rd_status :
                          (a_ofs == OFS_INT_STAT)  ? rd_stat :
                          (a_ofs == OFS_INT_MASK)  ? rd_mask : 32'h00000000;

  wire [INT_W-1:0] stat_clr = wr_stat ? hwdata[INT_W-1:0] : '0;
  wire [INT_W-1:0] stat_nxt = (int_stat_r & ~stat_clr) | int_ev;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_ofs_r  <= 8'h00;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (hready) begin
        wr_pend_r <= a_valid && hwrite && a_hit;
        wr_ofs_r  <= a_ofs;
      end
      if (a_valid && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_stat_r <= INT_STAT_RST;
      int_mask_r <= INT_MASK_RST;
      irq_r      <= 1'b0;
    end else begin
      int_stat_r <= stat_nxt;
      if (wr_mask) begin
        int_mask_r <= hwdata[INT_W-1:0];
      end
      irq_r <= |(int_stat_r & int_mask_r);
    end
  end

  assign irq = irq_r;

endmodule

/* File: smpsq_top_asserts.sv */
// Concurrent checks on the ports of the power-good and fault sequencer
`timescale 1ns/1ps
module smpsq_top_asserts #(
  parameter int unsigned RAMP_CYCLES = 20
) (
  // Clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // Inputs watched
  input wire logic       output1_enable,
  input wire logic       supply_por_ok,
  input wire logic [1:0] vout_over,
  input wire logic       temp_over,
  // Outputs watched
  input wire logic       power_good_out_oe,
  input wire logic [1:0] gate_override,
  input wire logic [1:0] low_side_gate,
  input wire logic [1:0] high_side_gate,
  input wire logic [1:0] switching_en,
  input wire logic [1:0] forced_pwm,
  input wire logic [1:0] error_amp_ramp_up,
  input wire logic [1:0] error_amp_ramp_dn,
  input wire logic       discharge_en
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ==========================================================
  // Cycles both channels have switched with no ramp up
  logic [12:0] quiet_r;
  logic [12:0] quiet_nxt;
  assign quiet_nxt = (error_amp_ramp_up != 2'h0 || switching_en != 2'h3) ? 13'h0 :
                     (&quiet_r ? quiet_r : quiet_r + 13'h1);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      quiet_r <= 13'h0;
    end else begin
      quiet_r <= quiet_nxt;
    end
  end

  // ==========================================================
  // Fault sequences
  sequence s_ov0;
    (vout_over[0] && supply_por_ok) [*5];
  endsequence
  sequence s_hot;
    (temp_over && supply_por_ok) [*5];
  endsequence

  // ==========================================================
  // Assertions
  AST_PG_EN_LOW: assert property (!output1_enable [*4] |-> power_good_out_oe)
    else $error("power-good released with an enable low");
  AST_PG_RAMP: assert property (error_amp_ramp_up != 2'h0 |-> power_good_out_oe)
    else $error("power-good released during soft-start");
  AST_PG_DELAY: assert property ($fell(power_good_out_oe) |-> quiet_r >= 13'hFA0)
    else $error("power-good released too early");
  AST_PG_RUN: assert property (!power_good_out_oe |-> switching_en == 2'h3 && forced_pwm == 2'h0)
    else $error("power-good released with a controller not running");
  AST_OV_CLAMP: assert property (s_ov0 |-> power_good_out_oe && gate_override[0] && !switching_en[0])
    else $error("overvoltage did not stop and clamp output one");
  AST_HOT_OFF: assert property (s_hot |-> power_good_out_oe && discharge_en && low_side_gate == 2'h0)
    else $error("thermal fault did not shut down");
  AST_STOP_PWM: assert property (forced_pwm != 2'h0 |->
    (forced_pwm & error_amp_ramp_dn & switching_en) == forced_pwm)
    else $error("forced pwm outside soft-shutdown");
  AST_POR_SAFE: assert property ((!supply_por_ok) [*4] |->
    discharge_en && low_side_gate == 2'h3 && switching_en == 2'h0)
    else $error("unsafe gate state below power-on level");
  AST_HS_LOW: assert property (high_side_gate == 2'h0)
    else $error("high side gate forced high");
endmodule

bind smpsq_top smpsq_top_asserts #(.RAMP_CYCLES(RAMP_CYCLES)) u_smpsq_top_asserts (
  .hclk, .hresetn, .output1_enable, .supply_por_ok, .vout_over, .temp_over,
  .power_good_out_oe, .gate_override, .low_side_gate, .high_side_gate, .switching_en,
  .forced_pwm, .error_amp_ramp_up, .error_amp_ramp_dn, .discharge_en);

/* File: tb_top.sv */
// Self-checking bench for the power-good and fault sequencer
`timescale 1ns/1ps
module tb_top;
  import smpsq_pkg::*;
  localparam int unsigned RAMP  = 20;
  localparam int          LIMIT = 60000;
  localparam logic [31:0] S_POR = 32'h1 << ST_POR;
  localparam logic [31:0] S_RUN = 32'h3 << ST_RUN;
  localparam logic [31:0] S_PG  = 32'h1 << ST_PG;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, discharge_en;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, req_en, vout_over, vout_under, vout_pg_ok, vout_near_zero;
  logic [2:0]  hsize;
  logic        output1_enable, output2_enable, linear_reg_enable, req_ldo, slow, pg_line;
  logic        supply_por_ok, supply_lockout, temp_over, temp_cooled;
  logic        power_good_out_o, power_good_out_oe;
  logic [1:0]  gate_override, low_side_gate, high_side_gate, switching_en, forced_pwm;
  logic [1:0]  error_amp_ramp_up, error_amp_ramp_dn;
  int          mismatches, comparisons, cycles;
  assign hready = hreadyout;

  smpsq_top #(.RAMP_CYCLES(RAMP)) u_smpsq_top (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .output1_enable,
    .output2_enable, .linear_reg_enable, .supply_por_ok, .supply_lockout, .vout_over,
    .vout_under, .vout_pg_ok, .vout_near_zero, .temp_over, .temp_cooled, .power_good_out_o,
    .power_good_out_oe, .gate_override, .low_side_gate, .high_side_gate, .switching_en,
    .forced_pwm, .error_amp_ramp_up, .error_amp_ramp_dn, .discharge_en, .irq);
  smpsq_sysctl_model u_smpsq_sysctl_model (.hclk, .hresetn, .req_en, .req_ldo, .slow,
    .power_good_out_o, .power_good_out_oe, .output1_enable, .output2_enable,
    .linear_reg_enable, .pg_line);

  // ==========================================================
  // Clock and hang guard
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      mismatches++;
      report_and_stop();
    end
  end

  // ==========================================================
  // Tasks
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task wait_pg(input int lim);
    int n;
    n = 0;
    while (power_good_out_oe !== 1'b0 && n < lim) begin
      @(posedge hclk);
      n++;
    end
    chk(32'(n >= RAMP + 4000 && n < lim), 32'h1);
    chk(32'(pg_line), 32'h1);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    hresetn = 1'b0; hsel = 1'b1; htrans = 2'h0; haddr = 32'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; req_en = 2'h0; req_ldo = 1'b1; slow = 1'b0;
    supply_por_ok = 1'b1; supply_lockout = 1'b0; vout_over = 2'h0; vout_under = 2'h0;
    vout_pg_ok = 2'h3; vout_near_zero = 2'h0; temp_over = 1'b0; temp_cooled = 1'b0;
    mismatches = 0; comparisons = 0; cycles = 0;
    tick(6);
    hresetn <= 1'b1;
    tick(4);
    ahb(1'b0, OFS_INT_MASK, 32'h0); chk(rd, {27'h0, INT_MASK_RST});
    ahb(1'b0, OFS_INT_STAT, 32'h0); chk(rd, {27'h0, INT_STAT_RST});
    ahb(1'b0, 8'h10, 32'h0);        chk(rd, 32'h0);
    chk(32'(hresp), 32'h0);
    ahb(1'b1, OFS_STATUS, 32'hFFFF);
    ahb(1'b0, OFS_STATUS, 32'h0);   chk(rd, S_POR);
    $display("test registers done");
    req_en <= 2'h3;
    wait_pg(5000);
    ahb(1'b0, OFS_STATUS, 32'h0);   chk(rd, S_POR | S_RUN | S_PG);
    $display("test start-up done");
    ahb(1'b1, OFS_INT_MASK, 32'h1 << EV_UV);
    vout_under <= 2'h2;
    vout_pg_ok <= 2'h1;
    tick(6);
    chk(32'(power_good_out_oe), 32'h1);
    chk(32'(forced_pwm), 32'h2);
    ahb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, S_POR | 32'h1 << ST_RUN | 32'h2 << ST_UV);
    chk(32'(irq), 32'h1);
    ahb(1'b1, OFS_INT_STAT, 32'h1 << EV_UV);
    tick(3);
    chk(32'(irq), 32'h0);
    ahb(1'b0, OFS_INT_STAT, 32'h0); chk(rd, 32'h1 << EV_PGLOST);
    ahb(1'b1, OFS_INT_STAT, 32'h1F);
    tick(RAMP + 5);
    vout_near_zero <= 2'h2;
    tick(5);
    chk(32'(low_side_gate[1] & gate_override[1] & ~switching_en[1]), 32'h1);
    vout_under     <= 2'h0;
    vout_pg_ok     <= 2'h3;
    vout_near_zero <= 2'h0;
    req_en <= 2'h1;
    tick(5);
    req_en <= 2'h3;
    wait_pg(5000);
    $display("test undervoltage done");
    vout_over <= 2'h1;
    slow      <= 1'b1;
    tick(5);
    chk(32'(power_good_out_oe & low_side_gate[0] & gate_override[0]), 32'h1);
    chk(32'(~switching_en[0] & error_amp_ramp_dn[0]), 32'h1);
    vout_over <= 2'h0;
    tick(10);
    ahb(1'b0, OFS_STATUS, 32'h0);   chk(rd, S_POR | 32'h2 << ST_RUN | 32'h1 << ST_OV);
    req_en <= 2'h2;
    tick(5);
    req_en <= 2'h3;
    wait_pg(5000);
    $display("test overvoltage done");
    temp_over <= 1'b1;
    tick(5);
    chk(32'(power_good_out_oe & discharge_en), 32'h1);
    chk(32'({low_side_gate, high_side_gate}), 32'h0);
    temp_over <= 1'b0;
    req_en    <= 2'h0;
    tick(5);
    req_en <= 2'h3;
    tick(5);
    ahb(1'b0, OFS_STATUS, 32'h0);   chk(rd, S_POR | 32'h1 << ST_THERM);
    temp_cooled <= 1'b1;
    req_ldo     <= 1'b0;
    tick(5);
    req_ldo <= 1'b1;
    wait_pg(5000);
    temp_cooled <= 1'b0;
    $display("test thermal done");
    supply_lockout <= 1'b1;
    tick(5);
    chk(32'({low_side_gate, switching_en}), 32'h0);
    ahb(1'b0, OFS_STATUS, 32'h0);   chk(rd, S_POR | 32'h1 << ST_LOCK);
    supply_por_ok <= 1'b0;
    tick(5);
    chk(32'({discharge_en, low_side_gate, switching_en}), 32'h1C);
    ahb(1'b0, OFS_STATUS, 32'h0);   chk(rd, 32'h1 << ST_LOCK);
    supply_por_ok <= 1'b1;
    tick(5);
    chk(32'({discharge_en, low_side_gate, switching_en}), 32'h1C);
    supply_lockout <= 1'b0;
    wait_pg(5000);
    $display("test supply done");
    report_and_stop();
  end
endmodule
